//--- common/cdb_pkg.sv
package cdb_pkg;
    localparam int unsigned CLK_MHZ       = 40;
    localparam int unsigned STROBE_NS     = 165;
    localparam int unsigned SETUP_NS      = 70;
    localparam int unsigned RECOVER_NS    = 50;
    localparam int unsigned STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RECOVER_CYC   = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W         = 4;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned ADDR_W        = 3;
    localparam int unsigned ODD_LSB       = 8;

    typedef enum logic [1:0]
    {
        CMD_TASKFILE = 2'b00,
        CMD_CONTROL  = 2'b01,
        CMD_DATA     = 2'b10,
        CMD_DMA      = 2'b11
    } cdb_kind_type;
endpackage

//--- common/cdb_strobe_if.sv
interface cdb_strobe_if;
    logic        start;
    logic [cdb_pkg::CNT_W-1:0] setup_cyc;
    logic [cdb_pkg::CNT_W-1:0] width_cyc;
    logic        active;
    logic        done;

    modport ctrl
    (
        output start,
        output setup_cyc,
        output width_cyc,
        input  active,
        input  done
    );
    modport timer
    (
        input  start,
        input  setup_cyc,
        input  width_cyc,
        output active,
        output done
    );
endinterface

//--- src/cdb_strobe_timer.sv
module cdb_strobe_timer
    import cdb_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  srst_i,
    cdb_strobe_if.timer st
);
    typedef enum logic [1:0]
    {
        T_IDLE  = 2'b00,
        T_SETUP = 2'b01,
        T_PULSE = 2'b10,
        T_DONE  = 2'b11
    } cdb_tstate_type;

    typedef struct packed
    {
        cdb_tstate_type   state;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] width;
    } cdb_tim_type;

    cdb_tim_type s_r;
    cdb_tim_type s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        case (s_r.state)
            T_IDLE:
            begin
                if (st.start)
                begin
                    s_nxt.state = T_SETUP;
                    s_nxt.cnt   = st.setup_cyc;
                    s_nxt.width = st.width_cyc;
                end
            end
            T_SETUP:
            begin
                if (s_r.cnt <= 4'h1)
                begin
                    s_nxt.state = T_PULSE;
                    s_nxt.cnt   = s_r.width;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            T_PULSE:
            begin
                if (s_r.cnt <= 4'h1)
                begin
                    s_nxt.state = T_DONE;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            default:
            begin
                s_nxt.state = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_r <= '{state: T_IDLE, cnt: '0, width: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign st.active = (s_r.state == T_PULSE);
    assign st.done   = (s_r.state == T_DONE);
endmodule

//--- src/cdb_host.sv
module cdb_host
    import cdb_pkg::*;
#(
    parameter int unsigned DW = DATA_W
)
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    // User request
    input  wire logic          req_valid_i,
    input  wire logic [1:0]    req_kind_i,
    input  wire logic          req_write_i,
    input  wire logic [2:0]    req_addr_i,
    input  wire logic [DW-1:0] req_wdata_i,
    input  wire logic          io_mode_i,
    output logic               req_ready_o,
    output logic               rsp_valid_o,
    output logic [DW-1:0]      rsp_rdata_o,
    output logic               rsp_ack_seen_o,
    // Card pins
    input  wire logic [DW-1:0] dat_in_i,
    output logic [DW-1:0]      dat_out_o,
    output logic               dat_oe_o,
    output logic [2:0]         addr_o,
    output logic               cs0_n_o,
    output logic               cs1_n_o,
    output logic               iord_n_o,
    output logic               iowr_n_o,
    output logic               dmack_n_o,
    input  wire logic          dmarq_i,
    input  wire logic          inpack_n_i
);
    typedef enum logic [2:0]
    {
        S_IDLE  = 3'b000,
        S_WAITQ = 3'b001,
        S_RUN   = 3'b010,
        S_DONE  = 3'b011,
        S_REC   = 3'b100
    } cdb_state_type;

    typedef struct packed
    {
        cdb_state_type    state;
        cdb_kind_type     kind;
        logic             write;
        logic [DW-1:0]    wdata;
        logic [DW-1:0]    rdata;
        logic [DW-1:0]    dout;
        logic             oe;
        logic [2:0]       addr;
        logic             cs0_n;
        logic             cs1_n;
        logic             iord_n;
        logic             iowr_n;
        logic             dmack_n;
        logic             ready;
        logic             rvalid;
        logic             ack_seen;
        logic [CNT_W-1:0] rcnt;
        logic [1:0]       rq_sync;
        logic [1:0]       ack_sync;
        logic [1:0]       io_sync;
        logic [DW-1:0]    din_s1;
        logic [DW-1:0]    din_s2;
    } cdb_host_type;

    cdb_host_type s_r;
    cdb_host_type s_nxt;
    cdb_strobe_if  st ();

    // Byte accesses use the even lane only; words use both lanes
    function automatic logic [DW-1:0] lane_fit(input cdb_kind_type k, input logic [DW-1:0] d);
        lane_fit = d;
        if ((k == CMD_TASKFILE) || (k == CMD_CONTROL))
        begin
            lane_fit = {{(DW-BYTE_W){1'b0}}, d[BYTE_W-1:0]};
        end
    endfunction

    cdb_strobe_timer u_tim
    (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .st     (st)
    );

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.rvalid   = 1'b0;
        s_nxt.rq_sync  = {s_r.rq_sync[0], dmarq_i};
        s_nxt.ack_sync = {s_r.ack_sync[0], ~inpack_n_i};
        s_nxt.io_sync  = {s_r.io_sync[0], io_mode_i};
        // The bus is only sampled deep inside a strobe, so lanes cannot skew apart
        s_nxt.din_s1   = dat_in_i;
        s_nxt.din_s2   = s_r.din_s1;
        st.start       = 1'b0;
        st.setup_cyc   = CNT_W'(SETUP_CYC);
        st.width_cyc   = CNT_W'(STROBE_CYC);
        case (s_r.state)
            S_IDLE:
            begin
                if (req_valid_i && s_r.ready)
                begin
                    s_nxt.ready    = 1'b0;
                    s_nxt.kind     = cdb_kind_type'(req_kind_i);
                    s_nxt.write    = req_write_i;
                    s_nxt.wdata    = lane_fit(cdb_kind_type'(req_kind_i), req_wdata_i);
                    s_nxt.ack_seen = 1'b0;
                    // Only A2..A0 are driven; upper address lines are grounded
                    s_nxt.addr     = req_addr_i;
                    if (cdb_kind_type'(req_kind_i) == CMD_DMA)
                    begin
                        s_nxt.addr  = 3'h0;
                        s_nxt.state = S_WAITQ;
                    end
                    else
                    begin
                        s_nxt.cs0_n = (cdb_kind_type'(req_kind_i) == CMD_CONTROL);
                        s_nxt.cs1_n = (cdb_kind_type'(req_kind_i) != CMD_CONTROL);
                        s_nxt.state = S_RUN;
                        st.start    = 1'b1;
                    end
                end
            end
            S_WAITQ:
            begin
                // Chip selects stay negated for the whole DMA cycle
                s_nxt.cs0_n = 1'b1;
                s_nxt.cs1_n = 1'b1;
                if (s_r.rq_sync[1])
                begin
                    s_nxt.dmack_n = 1'b0;
                    s_nxt.state   = S_RUN;
                    st.start      = 1'b1;
                end
            end
            S_RUN:
            begin
                // Direction of every transfer, DMA included, is set by which strobe pulses
                s_nxt.iord_n = ~(st.active && !s_r.write);
                s_nxt.iowr_n = ~(st.active && s_r.write);
                s_nxt.oe     = s_r.write;
                s_nxt.dout   = s_r.wdata;
                // Input acknowledge only means something in PC Card I/O mode
                if (st.active && !s_r.write && s_r.io_sync[1] && s_r.ack_sync[1])
                begin
                    s_nxt.ack_seen = 1'b1;
                end
                if (st.active && !s_r.write)
                begin
                    s_nxt.rdata = lane_fit(s_r.kind, s_r.din_s2);
                end
                if (st.done)
                begin
                    // Write data stays on the bus past the rising strobe edge
                    s_nxt.iord_n = 1'b1;
                    s_nxt.iowr_n = 1'b1;
                    s_nxt.state  = S_DONE;
                end
            end
            S_DONE:
            begin
                s_nxt.oe      = 1'b0;
                s_nxt.cs0_n   = 1'b1;
                s_nxt.cs1_n   = 1'b1;
                s_nxt.dmack_n = 1'b1;
                s_nxt.rvalid  = 1'b1;
                s_nxt.rcnt    = CNT_W'(RECOVER_CYC);
                s_nxt.state   = S_REC;
            end
            S_REC:
            begin
                // Recovery lets the card drop its request before it is sampled again
                if (s_r.rcnt <= 4'h1)
                begin
                    s_nxt.ready = 1'b1;
                    s_nxt.state = S_IDLE;
                end
                else
                begin
                    s_nxt.rcnt = s_r.rcnt - 4'h1;
                end
            end
            default:
            begin
                s_nxt.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_r         <= '0;
            s_r.state   <= S_IDLE;
            s_r.kind    <= CMD_TASKFILE;
            s_r.cs0_n   <= 1'b1;
            s_r.cs1_n   <= 1'b1;
            s_r.iord_n  <= 1'b1;
            s_r.iowr_n  <= 1'b1;
            s_r.dmack_n <= 1'b1;
            s_r.ready   <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign req_ready_o    = s_r.ready;
    assign rsp_valid_o    = s_r.rvalid;
    assign rsp_rdata_o    = s_r.rdata;
    assign rsp_ack_seen_o = s_r.ack_seen;
    assign dat_out_o      = s_r.dout;
    assign dat_oe_o       = s_r.oe;
    assign addr_o         = s_r.addr;
    assign cs0_n_o        = s_r.cs0_n;
    assign cs1_n_o        = s_r.cs1_n;
    assign iord_n_o       = s_r.iord_n;
    assign iowr_n_o       = s_r.iowr_n;
    assign dmack_n_o      = s_r.dmack_n;
endmodule

//--- sim/cdb_host_assertions.sv
module cdb_host_assertions
    import cdb_pkg::*;
#(
    parameter int unsigned DW = DATA_W
)
(
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire logic [DW-1:0] dat_out_o,
    input  wire logic          dat_oe_o,
    input  wire logic [2:0]    addr_o,
    input  wire logic          cs0_n_o,
    input  wire logic          cs1_n_o,
    input  wire logic          iord_n_o,
    input  wire logic          iowr_n_o,
    input  wire logic          dmack_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    property p_cs_idle_dma;
        !dmack_n_o |-> cs0_n_o && cs1_n_o;
    endproperty
    a_cs_idle_dma: assert property (p_cs_idle_dma) else $error("select during dma");
    property p_one_strobe;
        iord_n_o || iowr_n_o;
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_rd_float;
        !iord_n_o |-> !dat_oe_o;
    endproperty
    a_rd_float: assert property (p_rd_float) else $error("host drives on read");
    property p_wr_hold;
        $rose(iowr_n_o) && !$past(srst_i) |-> dat_oe_o && $stable(dat_out_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data dropped");
    property p_strobe_width;
        $fell(iord_n_o && iowr_n_o) |-> !(iord_n_o && iowr_n_o) [*7] ##1 (iord_n_o && iowr_n_o);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width");
    property p_setup;
        $fell(iord_n_o && iowr_n_o) && dmack_n_o |-> $past(!(cs0_n_o && cs1_n_o), 2);
    endproperty
    a_setup: assert property (p_setup) else $error("no select before strobe");
    property p_addr_hold;
        !(iord_n_o && iowr_n_o) |-> $stable(addr_o);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_cs_excl;
        cs0_n_o || cs1_n_o;
    endproperty
    a_cs_excl: assert property (p_cs_excl) else $error("both selects low");
endmodule

bind cdb_host cdb_host_assertions #(.DW(DW)) u_chk (.*);

//--- sim/cdb_card_model.sv
module cdb_card_model
    import cdb_pkg::*;
(
    // Bench control
    input  wire logic        clk_i,
    input  wire logic        io_mode_i,
    input  wire logic        slow_i,
    input  wire logic        load_i,
    input  wire logic [3:0]  words_i,
    // Host pins
    input  wire logic [2:0]  addr_i,
    input  wire logic        cs0_n_i,
    input  wire logic        cs1_n_i,
    input  wire logic        iord_n_i,
    input  wire logic        iowr_n_i,
    input  wire logic        dmack_n_i,
    input  wire logic [15:0] dat_i,
    output logic [15:0]      dat_o,
    output logic             dmarq_o,
    output logic             inpack_n_o
);
    logic [7:0]  tf_r [8] = '{default: 8'h00};
    logic [7:0]  ctl_r    = 8'h00;
    logic [15:0] word_r   = 16'h0000;
    logic [3:0]  left_r   = 4'h0;
    logic [3:0]  gap_r    = 4'h0;
    logic        ack_q    = 1'h1;
    logic        rq_r     = 1'h0;
    logic        junk_r   = 1'h0;
    logic        word_sel;
    logic [7:0]  pat;

    assign word_sel = !dmack_n_i || (!cs0_n_i && addr_i == 3'h0);
    assign pat = {8{junk_r}} ^ 8'h5A;
    // Undriven lanes toggle, so a stale value never passes for data
    always_comb
    begin
        dat_o = {pat, ~pat};
        if (!iord_n_i && word_sel)
            dat_o = word_r;
        else if (!iord_n_i && !cs0_n_i)
            dat_o = {pat, tf_r[addr_i]};
        else if (!iord_n_i && !cs1_n_i)
            dat_o = {pat, ctl_r};
    end
    assign inpack_n_o = !(io_mode_i && !iord_n_i && !(cs0_n_i && cs1_n_i));
    // Only device on the cable, so always selected and always driving
    assign dmarq_o = rq_r;

    always @(posedge iowr_n_i)
    begin
        if (word_sel)
            word_r <= dat_i;
        else if (!cs0_n_i)
            tf_r[addr_i] <= dat_i[7:0];
        else if (!cs1_n_i)
            ctl_r <= dat_i[7:0];
    end

    always @(posedge clk_i)
    begin
        junk_r <= !junk_r;
        ack_q <= dmack_n_i;
        if (load_i)
            left_r <= words_i;
        else if (ack_q && !dmack_n_i)
            left_r <= left_r - 4'h1;
        if (!dmack_n_i || load_i)
            gap_r <= slow_i ? 4'h8 : 4'h1;
        else if (gap_r != 4'h0)
            gap_r <= gap_r - 4'h1;
        if (!dmack_n_i)
            rq_r <= 1'h0;
        else if (left_r != 4'h0 && gap_r == 4'h0)
            rq_r <= 1'h1;
    end
endmodule

//--- sim/tb_top.sv
module tb_top
    import cdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'h0, srst_i = 1'h1, req_valid_i = 1'h0, req_write_i = 1'h0;
    logic        io_mode_i = 1'h0, slow_i = 1'h0, load_i = 1'h0;
    logic        stray_ack = 1'h0;
    logic [1:0]  req_kind_i = 2'h0;
    logic [2:0]  req_addr_i = 3'h0;
    logic [15:0] req_wdata_i = 16'h0000;
    logic [3:0]  words_i = 4'h0;
    logic        req_ready_o, rsp_valid_o, rsp_ack_seen_o, dat_oe_o, cs0_n_o, cs1_n_o;
    logic        iord_n_o, iowr_n_o, dmack_n_o, dmarq_i, inpack_n_i, ack;
    logic [15:0] rsp_rdata_o, dat_out_o, card_dat, rd;
    logic [2:0]  addr_o;
    wire  [15:0] dat_in_i = dat_oe_o ? dat_out_o : card_dat;
    int          miscompares = 0;
    int          check_count = 0;

    cdb_host DUT (.*);
    cdb_card_model card (.clk_i(clk_i), .io_mode_i(io_mode_i || stray_ack), .slow_i(slow_i),
        .load_i(load_i), .words_i(words_i), .addr_i(addr_o), .cs0_n_i(cs0_n_o),
        .cs1_n_i(cs1_n_o), .iord_n_i(iord_n_o), .iowr_n_i(iowr_n_o), .dmack_n_i(dmack_n_o),
        .dat_i(dat_in_i), .dat_o(card_dat), .dmarq_o(dmarq_i), .inpack_n_o(inpack_n_i));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input logic [1:0] k, input logic w, input logic [2:0] a,
                        input logic [15:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'h1)
        begin
            @(negedge clk_i);
            n++;
            if (n > 400)
                check(16'h0000, 16'h0001, "ready timeout");
            if (n > 400)
                complete_run();
        end
        req_valid_i = 1'h1;
        req_kind_i = k;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_valid_i = 1'h0;
        n = 0;
        while (rsp_valid_o !== 1'h1)
        begin
            @(negedge clk_i);
            n++;
            if (n > 400)
                check(16'h0000, 16'h0001, "answer timeout");
            if (n > 400)
                complete_run();
        end
        rd = rsp_rdata_o;
        ack = rsp_ack_seen_o;
    endtask

    task automatic t_taskfile();
        for (int a = 1; a < 8; a++)
            xfer(CMD_TASKFILE, 1'h1, 3'(a), {8'hC3, 8'h10 + 8'(a)});
        for (int a = 1; a < 8; a++)
        begin
            xfer(CMD_TASKFILE, 1'h0, 3'(a), 16'h0000);
            check(rd, {8'h00, 8'h10 + 8'(a)}, "task file");
        end
        $display("task file test done");
    endtask

    task automatic t_control();
        xfer(CMD_CONTROL, 1'h1, 3'h6, 16'h5A0E);
        xfer(CMD_CONTROL, 1'h0, 3'h6, 16'h0000);
        check(rd, 16'h000E, "control");
        xfer(CMD_TASKFILE, 1'h0, 3'h6, 16'h0000);
        check(rd, 16'h0016, "task file 6");
        $display("control test done");
    endtask

    task automatic t_data();
        xfer(CMD_DATA, 1'h1, 3'h0, 16'hBEEF);
        check({8'h00, card.word_r[7:0]}, 16'h00EF, "even byte");
        check({8'h00, card.word_r[15:8]}, 16'h00BE, "odd byte");
        xfer(CMD_DATA, 1'h0, 3'h0, 16'h0000);
        check(rd, 16'hBEEF, "data word");
        $display("data test done");
    endtask

    task automatic t_ack();
        for (int m = 0; m < 2; m++)
        begin
            io_mode_i = 1'(m);
            // In True IDE mode the card still answers, so ignoring it is really tested
            stray_ack = 1'(m == 0);
            repeat (4) @(negedge clk_i);
            xfer(CMD_TASKFILE, 1'h0, 3'h1, 16'h0000);
            check({15'h0000, ack}, 16'(m), "input ack");
        end
        io_mode_i = 1'h0;
        stray_ack = 1'h0;
        $display("input ack test done");
    endtask

    task automatic t_dma(input logic s);
        slow_i = s;
        words_i = 4'h3;
        load_i = 1'h1;
        @(negedge clk_i);
        load_i = 1'h0;
        xfer(CMD_DMA, 1'h1, 3'h0, 16'h1234);
        check(card.word_r, 16'h1234, "dma write");
        xfer(CMD_DMA, 1'h0, 3'h0, 16'h0000);
        check(rd, 16'h1234, "dma read");
        xfer(CMD_DMA, 1'h1, 3'h0, 16'h8001);
        check(card.word_r, 16'h8001, "dma last");
        repeat (12) @(negedge clk_i);
        check({15'h0000, dmack_n_o}, 16'h0001, "ack released");
        $display("dma test done");
    endtask

    initial
    begin
        repeat (16) @(negedge clk_i);
        srst_i = 1'h0;
        t_taskfile();
        t_control();
        t_data();
        t_ack();
        t_dma(1'h0);
        t_dma(1'h1);
        complete_run();
    end
endmodule
